// ===== sdci_pkg.sv
// Shared constants and types of the SMBus DAC command interface
package sdci_pkg;

	// ****************************************
	// Addresses
	// ****************************************
	localparam logic [6:0] ADDR_VAR0 = 7'h20;
	localparam logic [6:0] ADDR_VAR1 = 7'h21;
	localparam logic [6:0] ADDR_VAR2 = 7'h22;
	localparam logic [6:0] GROUP_ADDR = 7'h7e;

	// ****************************************
	// Command, address and data byte fields
	// ****************************************
	localparam int SYNC_BIT = 0;
	localparam int PD_BIT = 1;
	localparam int REF_BIT = 2;
	localparam int RW_BIT = 0;
	localparam int CODE_W = 10;
	localparam int HI_W = 2;

	// ****************************************
	// Bit counting and reset values
	// ****************************************
	localparam logic [3:0] CNT_ARM = 4'h7;
	localparam logic [3:0] CNT_ACK = 4'h8;
	localparam logic BUS_IDLE = 1'b1;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [CODE_W-1:0] CODE_RST = 10'h000;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_CMD = 3'b010,
		ST_LOW = 3'b011,
		ST_HIGH = 3'b100,
		ST_IGNORE = 3'b101
	} sdci_state_e;

	typedef struct packed {
		logic scl;
		logic sda;
	} sdci_pins_s;

	typedef struct packed {
		logic power_down;
		logic internal_ref_select;
		logic [CODE_W-1:0] code;
	} sdci_dac_s;

endpackage : sdci_pkg

// ===== sdci_sync.sv
// Two-flop synchroniser for bus pins into the core clock domain
`timescale 1ns/1ps
module sdci_sync #(
	parameter int W = 2,
	parameter logic [W-1:0] RST_VAL = '1
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic core_ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sdci_sync_s;

	sdci_sync_s r;
	sdci_sync_s n;

	always_comb begin
		n = r;
		n.s1 = d;
		n.s2 = r.s1;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			r <= '{s1: RST_VAL, s2: RST_VAL};
		end else if (core_ce) begin
			r <= n;
		end
	end

	assign q = r.s2;

endmodule : sdci_sync

// ===== sdci_link.sv
// Acknowledge driver clocked by the falling edge of the bus clock
`timescale 1ns/1ps
module sdci_link (
	input wire logic scl_clk,
	input wire logic rst,
	input wire logic arm,
	output logic sda_oe_n
);
	typedef struct packed {
		logic oe_n;
	} sdci_link_s;

	sdci_link_s r;
	sdci_link_s n;

	// arm is set by the core within three core cycles of the previous falling edge, at least 50 ns before the falling edge that samples it
	// and stays put across that edge, so it is read here as qualified data.
	always_comb begin
		n = r;
		if (!r.oe_n) begin
			n.oe_n = 1'b1;
		end else if (arm) begin
			n.oe_n = 1'b0;
		end
	end

	// Bus clock stops outside frames, so reset must not wait for its edges
	always_ff @(negedge scl_clk or posedge rst) begin
		if (rst) begin
			r <= '{oe_n: 1'b1};
		end else begin
			r <= n;
		end
	end

	assign sda_oe_n = r.oe_n;

endmodule : sdci_link

// ===== sdci_core.sv
// Receive-only SMBus slave that loads a 10-bit DAC code and its command settings
// What this block does
// [R01] Answers one fixed seven-bit address chosen among three variants.
// [R02] Command bit 0 picks group-address update or update on STOP.
// [R03] Command bit 1 requests power-down; zero keeps normal operation.
// [R04] Command bit 2 picks internal reference; zero picks the supply.
// [R05] With sync clear, STOP copies input registers into output latches.
// [R06] With sync set, STOP does not update; group acknowledge does.
// [R07] Master chains repeated starts and one final STOP for joint update.
// [R08] Power-down takes effect at the next STOP; a group clear also drops it.
// [R09] Power-down keeps all latched data intact.
// [R10] First data byte gives code bits 7 to 0.
// [R11] Second data byte bits 1 and 0 give code bits 9 and 8.
// [R12] A command-only Send Byte transaction is accepted.
// [R13] START or STOP after command ack and before last ack drops data.
// [R14] START or STOP before command ack drops the partial command.
// [R15] Also answers group address 1111110 as a quick command.
// [R16] Group command with bit one updates latches only if sync was set.
// [R17] Group command with bit zero clears all latches always.
// [R18] Word write: address, command, low byte, high byte, each acknowledged.
// [R19] Acknowledge holds data low through the whole ack clock high phase.
// [R20] Foreign addresses get no acknowledge and the rest is ignored.
// [R21] Reset clears command, input and output latches to zero.
`timescale 1ns/1ps
module sdci_core #(
	parameter int VARIANT = 0
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic core_ce,
	input wire logic scl_clk,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n,
	output sdci_pkg::sdci_dac_s dac_out,
	output logic update_sync_select
);
	// ****************************************
	// Own address
	// ****************************************
	// [R01] Variant address
	localparam logic [6:0] OWN_ADDR = (VARIANT == 2) ? sdci_pkg::ADDR_VAR2 :
		(VARIANT == 1) ? sdci_pkg::ADDR_VAR1 : sdci_pkg::ADDR_VAR0;

	typedef struct packed {
		sdci_pkg::sdci_state_e st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic scl_d;
		logic sda_d;
		logic arm;
		logic [7:0] cmd;
		logic [7:0] lo_stage;
		logic [7:0] lo;
		logic [7:0] hi;
		sdci_pkg::sdci_dac_s dac;
		logic sda_o;
	} sdci_core_s;

	localparam sdci_core_s CORE_RST = '{
		st: sdci_pkg::ST_IDLE,
		cnt: 4'h0,
		sh: sdci_pkg::BYTE_RST,
		scl_d: sdci_pkg::BUS_IDLE,
		sda_d: sdci_pkg::BUS_IDLE,
		arm: 1'b0,
		cmd: sdci_pkg::BYTE_RST,
		lo_stage: sdci_pkg::BYTE_RST,
		lo: sdci_pkg::BYTE_RST,
		hi: sdci_pkg::BYTE_RST,
		dac: '{power_down: 1'b0, internal_ref_select: 1'b0, code: sdci_pkg::CODE_RST},
		sda_o: 1'b0
	};

	sdci_core_s r;
	sdci_core_s n;
	sdci_pkg::sdci_pins_s pins_raw;
	sdci_pkg::sdci_pins_s pins;
	logic rise;
	logic fall;
	logic start_seen;
	logic stop_seen;
	logic arm_ok;
	logic [sdci_pkg::CODE_W-1:0] in_code;
	logic sync_sel;
	logic group_fire;
	logic word_done;

	// ****************************************
	// Pin capture and ack driver
	// ****************************************
	assign pins_raw = '{scl: scl_clk, sda: sda_i};

	sdci_sync #(
		.W(2),
		.RST_VAL(2'h3)
	) u_sync (
		.core_clk(core_clk),
		.rst(rst),
		.core_ce(core_ce),
		.d(pins_raw),
		.q(pins)
	);

	// [R19] Ack on falling edges
	sdci_link u_link (
		.scl_clk(scl_clk),
		.rst(rst),
		.arm(r.arm),
		.sda_oe_n(sda_oe_n)
	);

	// ****************************************
	// Bus events
	// ****************************************
	// Both pins share the same synchroniser delay, so their relative order is kept
	assign rise = pins.scl && !r.scl_d;
	assign fall = !pins.scl && r.scl_d;
	assign start_seen = pins.scl && r.scl_d && r.sda_d && !pins.sda;
	assign stop_seen = pins.scl && r.scl_d && !r.sda_d && pins.sda;

	// [R10] [R11] Code assembly
	assign in_code = {r.hi[sdci_pkg::HI_W-1:0], r.lo};
	assign sync_sel = r.cmd[sdci_pkg::SYNC_BIT];
	assign group_fire = rise && r.cnt == sdci_pkg::CNT_ACK && r.st == sdci_pkg::ST_ADDR &&
		r.sh[7:1] == sdci_pkg::GROUP_ADDR;
	assign word_done = rise && r.cnt == sdci_pkg::CNT_ACK && r.st == sdci_pkg::ST_HIGH;

	// [R20] Ack only own or group address
	always_comb begin
		arm_ok = 1'b0;
		if (r.st == sdci_pkg::ST_ADDR) begin
			arm_ok = r.sh[6:0] == OWN_ADDR || r.sh[6:0] == sdci_pkg::GROUP_ADDR;
		end else if (r.st == sdci_pkg::ST_CMD || r.st == sdci_pkg::ST_LOW ||
			r.st == sdci_pkg::ST_HIGH) begin
			arm_ok = 1'b1;
		end
	end

	// ****************************************
	// Transaction engine
	// ****************************************
	always_comb begin
		n = r;
		n.scl_d = pins.scl;
		n.sda_d = pins.sda;
		n.sda_o = 1'b0;
		if (start_seen || stop_seen) begin
			// [R13] [R14] Interrupted frame drops staged bytes
			n.cnt = 4'h0;
			n.arm = 1'b0;
			n.st = start_seen ? sdci_pkg::ST_ADDR : sdci_pkg::ST_IDLE;
			if (stop_seen) begin
				// [R08] Power-down waits for STOP
				n.dac.power_down = r.cmd[sdci_pkg::PD_BIT];
				// [R05] [R06] STOP update unless sync
				if (!sync_sel) begin
					n.dac.code = in_code;
					n.dac.internal_ref_select = r.cmd[sdci_pkg::REF_BIT];
				end
			end
		end else if (rise) begin
			if (r.cnt == sdci_pkg::CNT_ACK) begin
				n.cnt = 4'h0;
				n.arm = 1'b0;
				case (r.st)
					sdci_pkg::ST_ADDR: begin
						// [R15] Quick command ends after the ack
						n.st = sdci_pkg::ST_IGNORE;
						if (r.sh[7:1] == OWN_ADDR && !r.sh[sdci_pkg::RW_BIT]) begin
							n.st = sdci_pkg::ST_CMD;
						end else if (group_fire) begin
							if (!r.sh[sdci_pkg::RW_BIT]) begin
								// [R17] Group clear
								n.cmd = sdci_pkg::BYTE_RST;
								n.lo_stage = sdci_pkg::BYTE_RST;
								n.lo = sdci_pkg::BYTE_RST;
								n.hi = sdci_pkg::BYTE_RST;
								n.dac = CORE_RST.dac;
							end else if (sync_sel) begin
								// [R16] Group update
								n.dac.code = in_code;
								n.dac.internal_ref_select = r.cmd[sdci_pkg::REF_BIT];
							end
						end
					end
					sdci_pkg::ST_CMD: begin
						// [R02] [R03] [R04] [R12] Command kept at its ack
						n.cmd = r.sh;
						n.st = sdci_pkg::ST_LOW;
					end
					sdci_pkg::ST_LOW: begin
						n.lo_stage = r.sh;
						n.st = sdci_pkg::ST_HIGH;
					end
					sdci_pkg::ST_HIGH: begin
						// [R18] Both data bytes committed together
						n.lo = r.lo_stage;
						n.hi = r.sh;
						n.st = sdci_pkg::ST_IGNORE;
					end
					default: begin
					end
				endcase
			end else begin
				n.cnt = r.cnt + 4'h1;
				n.sh = {r.sh[6:0], pins.sda};
			end
		end else if (fall && r.cnt == sdci_pkg::CNT_ARM && arm_ok) begin
			// Arms before the eighth falling edge, which is when the driver samples it
			n.arm = 1'b1;
		end
	end

	// [R21] Reset clears all latches
	always_ff @(posedge core_clk) begin
		if (rst) begin
			r <= CORE_RST;
		end else if (core_ce) begin
			r <= n;
		end
	end

	// [R09] Code latches are untouched by power-down
	assign dac_out = r.dac;
	assign update_sync_select = r.cmd[sdci_pkg::SYNC_BIT];
	assign sda_o = r.sda_o;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	a_nack_foreign: assert property ( // [R20]
		r.st == sdci_pkg::ST_ADDR && core_ce && fall && r.cnt == sdci_pkg::CNT_ARM &&
		r.sh[6:0] != OWN_ADDR && r.sh[6:0] != sdci_pkg::GROUP_ADDR |=> !r.arm)
		else $error("arm raised for a foreign address");

	a_own_addr_arm: assert property ( // [R01]
		$rose(r.arm) && $past(r.st) == sdci_pkg::ST_ADDR |->
		$past(r.sh[6:0]) == OWN_ADDR || $past(r.sh[6:0]) == sdci_pkg::GROUP_ADDR)
		else $error("address ack without match");

	a_stop_update: assert property ( // [R05]
		stop_seen && core_ce && !sync_sel |=> r.dac.code == $past(in_code))
		else $error("STOP did not load the code");

	a_sync_no_stop: assert property ( // [R06]
		stop_seen && core_ce && sync_sel |=> $stable(r.dac.code))
		else $error("code changed on STOP in sync mode");

	a_pd_on_stop: assert property ( // [R08]
		$changed(r.dac.power_down) |-> $past(stop_seen) || $past(group_fire))
		else $error("power-down changed outside STOP");

	a_group_clear: assert property ( // [R17]
		group_fire && core_ce && !r.sh[sdci_pkg::RW_BIT] |=>
		r.dac.code == sdci_pkg::CODE_RST && r.cmd == sdci_pkg::BYTE_RST)
		else $error("group clear left state");

	a_group_update: assert property ( // [R16]
		group_fire && core_ce && r.sh[sdci_pkg::RW_BIT] |=>
		r.dac.code == ($past(sync_sel) ? $past(in_code) : $past(r.dac.code)))
		else $error("group update wrong");

	a_cmd_discard: assert property ( // [R14]
		(start_seen || stop_seen) && r.st == sdci_pkg::ST_CMD && core_ce |=> $stable(r.cmd))
		else $error("partial command kept");

	a_data_discard: assert property ( // [R13]
		(start_seen || stop_seen) && core_ce &&
		(r.st == sdci_pkg::ST_LOW || r.st == sdci_pkg::ST_HIGH) |=>
		$stable(r.lo) && $stable(r.hi))
		else $error("partial data kept");

	a_word_map: assert property ( // [R11]
		word_done && core_ce |=> r.lo == $past(r.lo_stage) && r.hi == $past(r.sh))
		else $error("data bytes mis-ordered");

	a_reset_zero: assert property ( // [R21]
		$past(rst) |-> r.dac == CORE_RST.dac && r.cmd == sdci_pkg::BYTE_RST)
		else $error("latches not cleared by reset");

	c_word_write: cover property (word_done && core_ce);
	c_group_update: cover property (group_fire && r.sh[sdci_pkg::RW_BIT] && sync_sel);
	c_group_clear: cover property (group_fire && !r.sh[sdci_pkg::RW_BIT]);
	c_send_byte: cover property (stop_seen && r.st == sdci_pkg::ST_LOW);

endmodule : sdci_core

// ===== sdci_host_model.sv
// SMBus bus master model driving the link pins
`timescale 1ns/1ps
module sdci_host_model (
	output logic scl,
	output logic sda_rel,
	input wire logic sda_wire
);
	// ****************
	// Bit and condition timing
	// ****************
	// SCL stands high between frames; released SDA rises through its pull-up
	initial begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end
	// Data moves 10 ns after SCL falls, so setup before the rise stays above two core cycles
	task automatic put_bit(input logic v, output logic s);
		#10 sda_rel = v;
		#52.5 scl = 1'b1;
		s = sda_wire;
		#62.5 scl = 1'b0;
	endtask : put_bit
	// start, also repeated from a low clock
	task automatic start_cond();
		#3.3;
		if (!scl) begin
			#10 sda_rel = 1'b1;
			#52.5 scl = 1'b1;
		end
		#100 sda_rel = 1'b0;
		#100 scl = 1'b0;
	endtask : start_cond
	task automatic stop_cond();
		#10 sda_rel = 1'b0;
		#52.5 scl = 1'b1;
		#100 sda_rel = 1'b1;
		#100;
	endtask : stop_cond
	task automatic put_byte(input logic [7:0] b, input int n, output logic ack);
		logic s;
		ack = 1'b1;
		for (int i = 0; i < n; i++) begin
			put_bit(b[7-i], s);
		end
		// released line sampled at the ack rise
		if (n == 8) begin
			put_bit(1'b1, ack);
		end
	endtask : put_byte
endmodule : sdci_host_model

// ===== smbus_dac_command_interface_tb.sv
// Self-checking bench of the SMBus DAC command interface
`timescale 1ns/1ps
module smbus_dac_command_interface_tb;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic core_ce = 1'b1;
	logic scl;
	logic sda_rel;
	logic sda_o;
	logic sda_oe_n;
	logic sync_sel;
	logic a;
	logic [15:0] r = 16'h99c5;
	logic [7:0] c;
	sdci_pkg::sdci_dac_s dac_out;
	sdci_pkg::sdci_dac_s e = '0;
	sdci_pkg::sdci_dac_s exp_q[$];
	int n_fail = 0;
	int checked = 0;
	wire logic sda_wire = sda_rel & (sda_oe_n | sda_o);
	always #12.5 core_clk = ~core_clk;
	sdci_host_model host (.scl(scl), .sda_rel(sda_rel), .sda_wire(sda_wire));
	sdci_core #(.VARIANT(0)) DUT (.core_clk(core_clk), .rst(rst), .core_ce(core_ce),
		.scl_clk(scl), .sda_i(sda_wire), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
		.dac_out(dac_out), .update_sync_select(sync_sel));
	// ****************
	// Checking helpers
	// ****************
	task automatic check(input logic [11:0] seen, input logic [11:0] want);
		checked++;
		if (seen !== want) begin
			n_fail++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, want);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("checked %0d failed %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	// A change with no note pending compares against the old value, so it fails
	always @(dac_out) begin
		if (!rst) begin
			check(dac_out, exp_q.size() > 0 ? exp_q.pop_front() : e);
		end
	end
	task automatic note(input sdci_pkg::sdci_dac_s v);
		if (v !== e) begin
			exp_q.push_back(v);
			e = v;
		end
	endtask : note
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr
	// Start, then n bytes from the top of d, each ack compared; no stop
	task automatic frame(input logic [31:0] d, input int n, input logic [3:0] na);
		host.start_cond();
		for (int i = 0; i < n; i++) begin
			host.put_byte(d[31-8*i -: 8], 8, a);
			check({11'h0, a}, {11'h0, na[3-i]});
		end
	endtask : frame
	task automatic fin(input string name);
		host.stop_cond();
		repeat (8) @(posedge core_clk);
		$display("test %s done", name);
	endtask : fin
	// ****************
	// Tests
	// ****************
	initial begin
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		repeat (3) @(posedge core_clk);
		check(dac_out, 12'h000);
		check({11'h0, sync_sel}, 12'h000);
		for (int k = 0; k < 4; k++) begin
			r = lfsr(r);
			c = {r[15:11], r[2], 2'b00};
			frame({8'h40, c, r[7:0], r[15:8]}, 4, 4'h0);
			note({1'b0, c[2], r[9:8], r[7:0]});
			fin("word write");
		end
		frame({8'h40, 8'h02, 16'h0}, 2, 4'h0);
		note({1'b1, 1'b0, e.code});
		fin("power down");
		frame({8'h40, 8'h00, 16'h0}, 2, 4'h0);
		note({1'b0, 1'b0, e.code});
		fin("wake");
		frame({8'h40, 8'h04, 8'h3c, 8'h0}, 3, 4'h0);
		note({1'b0, 1'b1, e.code});
		fin("data cut");
		host.start_cond();
		host.put_byte(8'h40, 8, a);
		host.put_byte(8'h03, 7, a);
		fin("command cut");
		check({11'h0, sync_sel}, 12'h000);
		frame({8'h46, 8'h01, 8'h11, 8'h01}, 4, 4'hf);
		fin("foreign address");
		check({11'h0, sync_sel}, 12'h000);
		frame({8'h40, 8'h01, 8'ha5, 8'h02}, 4, 4'h0);
		check({11'h0, sync_sel}, 12'h001);
		fin("sync write");
		note({1'b0, 1'b0, 10'h2a5});
		frame({8'hfd, 24'h0}, 1, 4'h0);
		fin("group update");
		note(12'h000);
		frame({8'hfc, 24'h0}, 1, 4'h0);
		fin("group clear");
		check({11'h0, sync_sel}, 12'h000);
		// Two words chained by a repeated start; only the last one reaches the output
		frame({8'h40, 8'h00, 8'h34, 8'h01}, 4, 4'h0);
		frame({8'h40, 8'h04, 8'h12, 8'h03}, 4, 4'h0);
		note({1'b0, 1'b1, 10'h312});
		fin("chained update");
		check(12'(exp_q.size()), 12'h000);
		tally_and_finish();
	end
	initial begin
		#200000;
		n_fail++;
		tally_and_finish();
	end
endmodule : smbus_dac_command_interface_tb
